// ---- src/scw_decoder.sv ----
/*
  Serial control word decoder: receives 16-bit words on the serial
  port, applies control words to six configuration registers, answers
  reads, forwards words down a cascade and sends converter samples.
  Assumes the host drives serial input and frame sync on the rising
  edge of o_sclk; both pins are asynchronous to i_clk. Reserved
  register bits are kept as written, so the host must write them zero.
  Addresses 6 and 7 are not built: writes drop, reads return zero.
*/
`timescale 1ns/1ps

// What this block does
// - A word with bit 15 set is a control word in programming or mixed mode.
// - In programming mode a word with bit 15 clear is invalid, never applied.
// - Bit 14 clear writes the data field into the addressed register.
// - Bit 14 set sends the addressed register out in the data field.
// - Only words whose device address bits 13..11 are zero act on this device.
// - A nonzero device address is decremented and the word forwarded.
// - Bits 10..8 pick one of eight register addresses.
// - Bits 7..0 carry the register value, used only for device address zero.
// - Serial mode bit 0 selects programming mode (0) or data mode (1).
// - Serial mode bit 1 enables mixed control and data mode.
// - Serial mode bit 3 enables serial port loop-back.
// - Serial mode bits 6..4 hold the cascade device count, bit 4 lowest.
// - Writing 1 to serial mode bit 7 starts a software reset.
// - Clock rate bits 1..0 hold the decimation rate code.
// - Clock rate bits 3..2 hold the serial clock divider code.
// - Clock rate bits 6..4 hold the master clock divider code.
// - Clock rate bit 7 echoes control words that write this device to serial output.
// - Power bit 0 powers all six channels; bits 1..4 and 7 are stored as written.
// - Power bit 5 powers the on-chip reference.
// - Power bit 6 enables the buffered reference output pin.
// - Each pair register holds lower gain in bits 2..0, higher in 6..4.
// - Pair bit 3 powers the lower channel, bit 7 the higher one.
// - Mixed mode marks frames by bit 15, giving samples 15 bits.
// - Data mode ignores all input and only outputs converter data.
// - Registers update on the falling edge of the serial clock.
// - Global power-up powers all six channels regardless of channel bits.
module scw_decoder (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Serial port pins
  input wire logic i_sdi,
  input wire logic i_sdifs,
  output logic o_sclk,
  output logic o_sdo,
  output logic o_sdofs,
  // Converter samples
  input wire logic [15:0] i_adc_word,
  input wire logic i_adc_valid,
  // Serial port configuration
  output logic o_operating_mode_select,
  output logic o_mixed_mode_enable,
  output logic o_port_loopback_enable,
  output logic [2:0] o_device_count,
  // Clock configuration
  output logic [1:0] o_decimation_rate,
  output logic [1:0] o_serial_clock_divider,
  output logic [2:0] o_master_clock_divider,
  output logic o_control_echo_enable,
  // Power and reference
  output logic o_global_power_up,
  output logic o_reference_power_up,
  output logic o_reference_output_enable,
  // Channels
  output logic [17:0] o_ch_gain,
  output logic [5:0] o_ch_power_on,
  // Status
  output logic o_invalid_word
);

  typedef struct packed {
    logic sdi_meta;
    logic sdi_sync;
    logic fs_meta;
    logic fs_sync;
    scw_pkg::scw_rx_state_type rx_st;
    logic [3:0] rx_cnt;
    logic [14:0] rx_sr;
    scw_pkg::scw_tx_state_type tx_st;
    logic [3:0] tx_cnt;
    logic [15:0] tx_sr;
    logic [15:0] pend_word;
    logic pend_valid;
    logic [5:0][7:0] regs;
    logic [5:0] ch_pwr;
    logic sdo;
    logic sdofs;
    logic invalid;
  } scw_state_type;

  scw_state_type s_q;
  scw_state_type s_d;
  logic clk_rise;
  logic clk_fall;
  logic clk_sclk;

  // ==========================================================
  // Serial clock
  // ==========================================================
  scw_clk_gen u_clk_gen (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_mcd_code(s_q.regs[scw_pkg::SCW_REG_CLOCK][scw_pkg::SCW_MCD_LO +: 3]),
    .i_scd_code(s_q.regs[scw_pkg::SCW_REG_CLOCK][scw_pkg::SCW_SCD_LO +: 2]),
    .o_sclk(clk_sclk),
    .o_rise(clk_rise),
    .o_fall(clk_fall)
  );

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    logic [15:0] word;
    logic done;
    logic mode_data;
    logic mode_mixed;
    logic [2:0] dev;
    logic [2:0] ridx;
    logic [7:0] rdata;
    logic loop_on;
    word = '0;
    done = 1'b0;
    mode_data = 1'b0;
    mode_mixed = 1'b0;
    dev = '0;
    ridx = '0;
    rdata = '0;
    loop_on = 1'b0;
    s_d = s_q;
    s_d.invalid = 1'b0;

    // Pins cross into the system clock through two stages
    s_d.sdi_meta = i_sdi;
    s_d.sdi_sync = s_q.sdi_meta;
    s_d.fs_meta = i_sdifs;
    s_d.fs_sync = s_q.fs_meta;

    // ====================
    // Receive, sampled at the falling serial edge
    // Sync is looked at only between words; a mid-word pulse is ignored
    if (clk_fall) begin
      case (s_q.rx_st)
        scw_pkg::SCW_RX_IDLE: begin
          if (s_q.fs_sync) begin
            s_d.rx_sr = {s_q.rx_sr[13:0], s_q.sdi_sync};
            s_d.rx_cnt = scw_pkg::SCW_FIRST_CNT;
            s_d.rx_st = scw_pkg::SCW_RX_SHIFT;
          end
        end
        scw_pkg::SCW_RX_SHIFT: begin
          if (s_q.rx_cnt == scw_pkg::SCW_LAST_BIT) begin
            done = 1'b1;
            word = {s_q.rx_sr, s_q.sdi_sync};
            s_d.rx_cnt = '0;
            s_d.rx_st = scw_pkg::SCW_RX_IDLE;
          end else begin
            s_d.rx_sr = {s_q.rx_sr[13:0], s_q.sdi_sync};
            s_d.rx_cnt = s_q.rx_cnt + 4'h1;
          end
        end
        default: begin
          s_d.rx_st = scw_pkg::SCW_RX_IDLE;
          s_d.rx_cnt = '0;
        end
      endcase
    end

    // ====================
    // Transmit, driven at the rising serial edge
    // One-word slot: a newer load replaces a word not yet started
    if (clk_rise) begin
      case (s_q.tx_st)
        scw_pkg::SCW_TX_IDLE: begin
          s_d.sdo = 1'b0;
          s_d.sdofs = 1'b0;
          if (s_q.pend_valid) begin
            s_d.sdo = s_q.pend_word[scw_pkg::SCW_FLAG_BIT];
            s_d.sdofs = 1'b1;
            s_d.tx_sr = {s_q.pend_word[14:0], 1'b0};
            s_d.tx_cnt = '0;
            s_d.pend_valid = 1'b0;
            s_d.tx_st = scw_pkg::SCW_TX_SHIFT;
          end
        end
        scw_pkg::SCW_TX_SHIFT: begin
          s_d.sdofs = 1'b0;
          if (s_q.tx_cnt == scw_pkg::SCW_LAST_BIT) begin
            s_d.sdo = 1'b0;
            s_d.tx_st = scw_pkg::SCW_TX_IDLE;
          end else begin
            s_d.sdo = s_q.tx_sr[15];
            s_d.tx_sr = {s_q.tx_sr[14:0], 1'b0};
            s_d.tx_cnt = s_q.tx_cnt + 4'h1;
          end
        end
        default: begin
          s_d.tx_st = scw_pkg::SCW_TX_IDLE;
          s_d.sdo = 1'b0;
          s_d.sdofs = 1'b0;
        end
      endcase
    end

    mode_mixed = s_q.regs[scw_pkg::SCW_REG_MODE][scw_pkg::SCW_MIXED_BIT];
    mode_data = s_q.regs[scw_pkg::SCW_REG_MODE][scw_pkg::SCW_MODE_SEL_BIT]
      & ~mode_mixed;
    // Loop-back is diagnostic only; data mode must send samples alone
    loop_on = s_q.regs[scw_pkg::SCW_REG_MODE][scw_pkg::SCW_LOOP_BIT]
      & ~mode_data;

    // ====================
    // Converter samples; later loads below take priority
    if (i_adc_valid) begin
      if (mode_data) begin
        s_d.pend_word = i_adc_word;
        s_d.pend_valid = 1'b1;
      end else if (mode_mixed) begin
        // Flag bit clear marks data; lowest sample bit is dropped
        s_d.pend_word = {1'b0, i_adc_word[15:1]};
        s_d.pend_valid = 1'b1;
      end
    end

    // ====================
    // Word decode
    dev = word[scw_pkg::SCW_DEV_HI:scw_pkg::SCW_DEV_LO];
    ridx = word[scw_pkg::SCW_REG_HI:scw_pkg::SCW_REG_LO];
    if (ridx < scw_pkg::SCW_NUM_REGS_IDX) begin
      rdata = s_q.regs[ridx];
    end else begin
      rdata = 8'h00;
    end

    if (done) begin
      if (loop_on) begin
        // Diagnostic path returns the frame untouched
        s_d.pend_word = word;
        s_d.pend_valid = 1'b1;
      end
      if (mode_data) begin
        // Input is ignored entirely in data mode
        s_d.invalid = 1'b0;
      end else if (!word[scw_pkg::SCW_FLAG_BIT]) begin
        // Mixed mode: a clear flag is host data, not an error
        s_d.invalid = ~mode_mixed;
      end else if (dev != scw_pkg::SCW_DEV_SELF) begin
        s_d.pend_word = word;
        s_d.pend_word[scw_pkg::SCW_DEV_HI:scw_pkg::SCW_DEV_LO] =
          dev - scw_pkg::SCW_DEV_STEP;
        s_d.pend_valid = 1'b1;
      end else if (word[scw_pkg::SCW_RW_BIT]) begin
        s_d.pend_word = {word[15:8], rdata};
        s_d.pend_valid = 1'b1;
      end else begin
        if (ridx < scw_pkg::SCW_NUM_REGS_IDX) begin
          s_d.regs[ridx] = word[scw_pkg::SCW_DATA_HI:0];
        end
        if (ridx == 3'(scw_pkg::SCW_REG_MODE)
            && word[scw_pkg::SCW_SWRESET_BIT]) begin
          for (int r = 0; r < scw_pkg::SCW_NUM_REGS; r++) begin
            s_d.regs[r] = scw_pkg::SCW_REG_RESET_VAL;
          end
        end
        if (s_q.regs[scw_pkg::SCW_REG_CLOCK][scw_pkg::SCW_ECHO_BIT]) begin
          s_d.pend_word = word;
          s_d.pend_valid = 1'b1;
        end
      end
    end

    // ====================
    // Channel power, held in flops for glitch-free outputs
    for (int c = 0; c < scw_pkg::SCW_NUM_CH; c++) begin
      s_d.ch_pwr[c] =
        s_d.regs[scw_pkg::SCW_REG_POWER][scw_pkg::SCW_GPU_BIT]
        | s_d.regs[scw_pkg::SCW_REG_PAIR0 + c / 2]
                  [(c % 2) * scw_pkg::SCW_CH_STRIDE
                   + scw_pkg::SCW_CH_PWR_BIT];
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Serial clock is a flop inside the generator
  assign o_sclk = clk_sclk;
  assign o_sdo = s_q.sdo;
  assign o_sdofs = s_q.sdofs;
  assign o_invalid_word = s_q.invalid;

  assign o_operating_mode_select =
    s_q.regs[scw_pkg::SCW_REG_MODE][scw_pkg::SCW_MODE_SEL_BIT];
  assign o_mixed_mode_enable =
    s_q.regs[scw_pkg::SCW_REG_MODE][scw_pkg::SCW_MIXED_BIT];
  assign o_port_loopback_enable =
    s_q.regs[scw_pkg::SCW_REG_MODE][scw_pkg::SCW_LOOP_BIT];
  assign o_device_count =
    s_q.regs[scw_pkg::SCW_REG_MODE][scw_pkg::SCW_DEVCNT_LO +: 3];

  assign o_decimation_rate =
    s_q.regs[scw_pkg::SCW_REG_CLOCK][scw_pkg::SCW_DECIM_LO +: 2];
  assign o_serial_clock_divider =
    s_q.regs[scw_pkg::SCW_REG_CLOCK][scw_pkg::SCW_SCD_LO +: 2];
  assign o_master_clock_divider =
    s_q.regs[scw_pkg::SCW_REG_CLOCK][scw_pkg::SCW_MCD_LO +: 3];
  assign o_control_echo_enable =
    s_q.regs[scw_pkg::SCW_REG_CLOCK][scw_pkg::SCW_ECHO_BIT];

  // Reserved power bits are stored as written; software keeps them zero
  assign o_global_power_up =
    s_q.regs[scw_pkg::SCW_REG_POWER][scw_pkg::SCW_GPU_BIT];
  assign o_reference_power_up =
    s_q.regs[scw_pkg::SCW_REG_POWER][scw_pkg::SCW_REFPU_BIT];
  assign o_reference_output_enable =
    s_q.regs[scw_pkg::SCW_REG_POWER][scw_pkg::SCW_BUFFERED_REFERENCE_PIN_BIT];

  assign o_ch_power_on = s_q.ch_pwr;

  genvar g;
  generate
    for (g = 0; g < scw_pkg::SCW_NUM_CH; g++) begin : gen_ch
      assign o_ch_gain[g * scw_pkg::SCW_GAIN_W +: scw_pkg::SCW_GAIN_W] =
        s_q.regs[scw_pkg::SCW_REG_PAIR0 + g / 2]
                [(g % 2) * scw_pkg::SCW_CH_STRIDE +: scw_pkg::SCW_GAIN_W];
    end
  endgenerate

endmodule

// ---- src/scw_pkg.sv ----
/*
  Constants and types shared by the serial control word decoder.
  Assumes a single 100 MHz system clock; serial timing derives from it.
*/
package scw_pkg;

  // ==========================================================
  // Control word fields
  // ==========================================================
  localparam int SCW_WORD_W = 16;
  localparam int SCW_FLAG_BIT = 15;
  localparam int SCW_RW_BIT = 14;
  localparam int SCW_DEV_HI = 13;
  localparam int SCW_DEV_LO = 11;
  localparam int SCW_REG_HI = 10;
  localparam int SCW_REG_LO = 8;
  localparam int SCW_DATA_HI = 7;
  localparam logic [2:0] SCW_DEV_SELF = 3'h0;
  localparam logic [2:0] SCW_DEV_STEP = 3'h1;
  localparam logic [3:0] SCW_LAST_BIT = 4'hF;
  localparam logic [3:0] SCW_FIRST_CNT = 4'h1;

  // ==========================================================
  // Register file
  // ==========================================================
  localparam int SCW_NUM_REGS = 6;
  localparam logic [2:0] SCW_NUM_REGS_IDX = 3'h6;
  localparam int SCW_REG_MODE = 0;
  localparam int SCW_REG_CLOCK = 1;
  localparam int SCW_REG_POWER = 2;
  localparam int SCW_REG_PAIR0 = 3;
  localparam logic [7:0] SCW_REG_RESET_VAL = 8'h00;

  // Serial mode register
  localparam int SCW_MODE_SEL_BIT = 0;
  localparam int SCW_MIXED_BIT = 1;
  localparam int SCW_LOOP_BIT = 3;
  localparam int SCW_DEVCNT_LO = 4;
  localparam int SCW_SWRESET_BIT = 7;

  // Clock rate register
  localparam int SCW_DECIM_LO = 0;
  localparam int SCW_SCD_LO = 2;
  localparam int SCW_MCD_LO = 4;
  localparam int SCW_ECHO_BIT = 7;

  // Reference and power register
  localparam int SCW_GPU_BIT = 0;
  localparam int SCW_REFPU_BIT = 5;
  localparam int SCW_BUFFERED_REFERENCE_PIN_BIT = 6;

  // Channel pair registers
  localparam int SCW_NUM_CH = 6;
  localparam int SCW_GAIN_W = 3;
  localparam int SCW_CH_STRIDE = 4;
  localparam int SCW_CH_PWR_BIT = 3;

  // ==========================================================
  // Serial clock timing
  // ==========================================================
  localparam int SCW_BASE_HALF = 4;
  localparam logic [2:0] SCW_MCD_MAX = 3'h4;

  // ==========================================================
  // State encodings
  // ==========================================================
  typedef enum logic [1:0] {
    SCW_RX_IDLE = 2'h0,
    SCW_RX_SHIFT = 2'h1
  } scw_rx_state_type;

  typedef enum logic [1:0] {
    SCW_TX_IDLE = 2'h0,
    SCW_TX_SHIFT = 2'h1
  } scw_tx_state_type;

endpackage

// ---- src/scw_clk_gen.sv ----
/*
  Serial clock generator: divides the system clock by the master and
  serial divider codes and flags each edge of the generated clock.
  Assumes codes come from registers on the same clock.
*/
`timescale 1ns/1ps

module scw_clk_gen (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Divider codes
  input wire logic [2:0] i_mcd_code,
  input wire logic [1:0] i_scd_code,
  // Generated clock and edge strobes
  output logic o_sclk,
  output logic o_rise,
  output logic o_fall
);

  typedef struct packed {
    logic [7:0] cnt;
    logic sclk;
    logic rise;
    logic fall;
  } scw_cg_state_type;

  scw_cg_state_type s_q;
  scw_cg_state_type s_d;
  logic [7:0] mdiv;
  logic [7:0] half;

  // ==========================================================
  // Half period in system cycles
  // ==========================================================
  always_comb begin
    // Unknown master codes fall back to divide by one
    if (i_mcd_code <= scw_pkg::SCW_MCD_MAX) begin
      mdiv = {5'h00, i_mcd_code} + 8'h01;
    end else begin
      mdiv = 8'h01;
    end
    half = 8'(scw_pkg::SCW_BASE_HALF) * (mdiv << i_scd_code);
  end

  always_comb begin
    s_d = s_q;
    s_d.rise = 1'b0;
    s_d.fall = 1'b0;
    if (s_q.cnt >= half - 8'h01) begin
      s_d.cnt = 8'h00;
      s_d.sclk = ~s_q.sclk;
      s_d.rise = ~s_q.sclk;
      s_d.fall = s_q.sclk;
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sclk = s_q.sclk;
  assign o_rise = s_q.rise;
  assign o_fall = s_q.fall;

endmodule

// ---- tb/scw_decoder_props.sv ----
/*
  Port checker for the serial control word decoder.
  Assumes one clock domain; it is bound in below the module.
*/
`timescale 1ns/1ps

module scw_decoder_props (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Serial port
  input wire logic i_sdi,
  input wire logic i_sdifs,
  input wire logic o_sclk,
  input wire logic o_sdo,
  input wire logic o_sdofs,
  // Samples
  input wire logic [15:0] i_adc_word,
  input wire logic i_adc_valid,
  // Configuration and status
  input wire logic o_operating_mode_select,
  input wire logic o_mixed_mode_enable,
  input wire logic o_port_loopback_enable,
  input wire logic [2:0] o_device_count,
  input wire logic [1:0] o_decimation_rate,
  input wire logic [1:0] o_serial_clock_divider,
  input wire logic [2:0] o_master_clock_divider,
  input wire logic o_control_echo_enable,
  input wire logic o_global_power_up,
  input wire logic o_reference_power_up,
  input wire logic o_reference_output_enable,
  input wire logic [17:0] o_ch_gain,
  input wire logic [5:0] o_ch_power_on,
  input wire logic o_invalid_word
);
  // ====================
  // Helpers
  // ====================
  logic [40:0] cfg;
  logic data_mode;

  assign cfg = {o_operating_mode_select, o_mixed_mode_enable,
    o_port_loopback_enable, o_device_count, o_decimation_rate,
    o_serial_clock_divider, o_master_clock_divider, o_control_echo_enable,
    o_global_power_up, o_reference_power_up, o_reference_output_enable,
    o_ch_gain, o_ch_power_on};
  // Mixed mode still takes control words, so it is left out
  assign data_mode = o_operating_mode_select & ~o_mixed_mode_enable;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  // ====================
  // Assertions
  // ====================
  a_invalid_pulse: assert property (o_invalid_word |=> !o_invalid_word)
    else $error("invalid flag held too long");
  a_invalid_mode: assert property (o_invalid_word |->
    !o_operating_mode_select && !o_mixed_mode_enable)
    else $error("invalid flag outside programming mode");
  a_invalid_no_write: assert property (o_invalid_word |-> $stable(cfg))
    else $error("invalid word changed a register");
  a_global_power: assert property (o_global_power_up |->
    o_ch_power_on == 6'h3F)
    else $error("global power did not power all channels");
  a_cfg_on_fall: assert property (!$stable(cfg) |-> !o_sclk &&
    ($past(o_sclk) || $past(o_sclk, 2) || $past(o_sclk, 3)))
    else $error("register changed away from a serial falling edge");
  a_sclk_half: assert property ($changed(o_sclk) |=>
    $stable(o_sclk) [*3])
    else $error("serial clock half period too short");
  a_sync_bit: assert property ($rose(o_sdofs) |=> o_sdofs [*3])
    else $error("output frame sync shorter than a bit");
  a_data_ignore: assert property (data_mode |=>
    $stable(cfg) && !o_invalid_word)
    else $error("input acted on in data mode");

  c_invalid: cover property (o_invalid_word);
  c_tx_word: cover property ($rose(o_sdofs));
  c_global: cover property ($rose(o_global_power_up));
endmodule

bind scw_decoder scw_decoder_props i_scw_decoder_props (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sdi(i_sdi), .i_sdifs(i_sdifs),
  .o_sclk(o_sclk), .o_sdo(o_sdo), .o_sdofs(o_sdofs),
  .i_adc_word(i_adc_word), .i_adc_valid(i_adc_valid),
  .o_operating_mode_select(o_operating_mode_select),
  .o_mixed_mode_enable(o_mixed_mode_enable),
  .o_port_loopback_enable(o_port_loopback_enable),
  .o_device_count(o_device_count), .o_decimation_rate(o_decimation_rate),
  .o_serial_clock_divider(o_serial_clock_divider),
  .o_master_clock_divider(o_master_clock_divider),
  .o_control_echo_enable(o_control_echo_enable),
  .o_global_power_up(o_global_power_up),
  .o_reference_power_up(o_reference_power_up),
  .o_reference_output_enable(o_reference_output_enable),
  .o_ch_gain(o_ch_gain), .o_ch_power_on(o_ch_power_on),
  .o_invalid_word(o_invalid_word)
);

// ---- tb/scw_host_model.sv ----
/*
  Host serial port model: sends words into the decoder, collects words.
  Assumes the decoder makes the serial clock and output frame sync.
*/
`timescale 1ns/1ps

module scw_host_model (
  // Decoder serial port
  input wire logic i_sclk,
  input wire logic i_sdo,
  input wire logic i_sdofs,
  output logic o_sdi,
  output logic o_sdifs
);
  logic [15:0] rx_shift;
  logic [15:0] rx_word;
  int rx_bits;
  int rx_count;

  initial begin
    o_sdi = 1'b0;
    o_sdifs = 1'b0;
    rx_bits = 0;
    rx_count = 0;
  end

  // ====================
  // Receive, MSB first
  // ====================
  always @(negedge i_sclk) begin
    if (i_sdofs) begin
      rx_shift = {15'h0, i_sdo};
      rx_bits = 1;
    end else if (rx_bits > 0) begin
      rx_shift = {rx_shift[14:0], i_sdo};
      rx_bits = rx_bits + 1;
    end
    if (rx_bits == 16) begin
      rx_word = rx_shift;
      rx_count = rx_count + 1;
      rx_bits = 0;
    end
  end

  // ====================
  // Transmit
  // ====================
  // Idle data is inverted so a stale bit is never mistaken for data
  task automatic send(input logic [15:0] word);
    for (int i = 15; i >= 0; i--) begin
      @(posedge i_sclk);
      o_sdifs <= (i == 15);
      o_sdi <= word[i];
    end
    @(posedge i_sclk);
    o_sdifs <= 1'b0;
    o_sdi <= ~word[0];
  endtask
endmodule

// ---- tb/scw_decoder_bench.sv ----
/*
  Self-checking bench for the serial control word decoder.
  Assumes the host model in scw_host_model.sv and the bound checker.
*/
`timescale 1ns/1ps

module scw_decoder_bench;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_sdi, i_sdifs, o_sclk, o_sdo, o_sdofs;
  logic [15:0] i_adc_word = 16'h0000;
  logic i_adc_valid = 1'b0;
  logic o_operating_mode_select, o_mixed_mode_enable;
  logic o_port_loopback_enable, o_control_echo_enable;
  logic o_global_power_up, o_reference_power_up;
  logic o_reference_output_enable, o_invalid_word;
  logic [2:0] o_device_count, o_master_clock_divider;
  logic [1:0] o_decimation_rate, o_serial_clock_divider;
  logic [17:0] o_ch_gain;
  logic [5:0] o_ch_power_on;
  logic [40:0] cfg;
  logic [7:0] sh [6];
  int num_errors = 0;
  int num_checks = 0;
  int inv_seen = 0;

  always #5 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    if (o_invalid_word === 1'b1) inv_seen++;
  end

  assign cfg = {o_operating_mode_select, o_mixed_mode_enable,
    o_port_loopback_enable, o_device_count, o_decimation_rate,
    o_serial_clock_divider, o_master_clock_divider, o_control_echo_enable,
    o_global_power_up, o_reference_power_up, o_reference_output_enable,
    o_ch_gain, o_ch_power_on};

  scw_decoder i_scw_decoder (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sdi(i_sdi), .i_sdifs(i_sdifs),
    .o_sclk(o_sclk), .o_sdo(o_sdo), .o_sdofs(o_sdofs),
    .i_adc_word(i_adc_word), .i_adc_valid(i_adc_valid),
    .o_operating_mode_select(o_operating_mode_select),
    .o_mixed_mode_enable(o_mixed_mode_enable),
    .o_port_loopback_enable(o_port_loopback_enable),
    .o_device_count(o_device_count), .o_decimation_rate(o_decimation_rate),
    .o_serial_clock_divider(o_serial_clock_divider),
    .o_master_clock_divider(o_master_clock_divider),
    .o_control_echo_enable(o_control_echo_enable),
    .o_global_power_up(o_global_power_up),
    .o_reference_power_up(o_reference_power_up),
    .o_reference_output_enable(o_reference_output_enable),
    .o_ch_gain(o_ch_gain), .o_ch_power_on(o_ch_power_on),
    .o_invalid_word(o_invalid_word)
  );

  scw_host_model i_scw_host_model (
    .i_sclk(o_sclk), .i_sdo(o_sdo), .i_sdofs(o_sdofs),
    .o_sdi(i_sdi), .o_sdifs(i_sdifs)
  );

  // ====================
  // Helpers
  // ====================
  function automatic logic [15:0] cw(input logic rw, input logic [2:0] dev,
    input logic [2:0] a, input logic [7:0] d);
    return {1'b1, rw, dev, a, d};
  endfunction

  function automatic logic [40:0] exp_cfg();
    logic [5:0] pw;
    pw = sh[2][0] ? 6'h3F : {sh[5][7], sh[5][3], sh[4][7], sh[4][3],
      sh[3][7], sh[3][3]};
    return {sh[0][0], sh[0][1], sh[0][3], sh[0][6:4], sh[1][1:0],
      sh[1][3:2], sh[1][6:4], sh[1][7], sh[2][0], sh[2][5], sh[2][6],
      sh[5][6:4], sh[5][2:0], sh[4][6:4], sh[4][2:0], sh[3][6:4],
      sh[3][2:0], pw};
  endfunction

  task automatic chk(input logic [40:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input int n, input logic [15:0] exp);
    int k;
    for (k = 0; k < 5000 && i_scw_host_model.rx_count == n; k++)
      @(posedge i_clk);
    if (i_scw_host_model.rx_count == n) begin
      num_errors++;
      $display("unexpected at %0t: no word out", $time);
      end_sim();
    end else begin
      chk(41'(i_scw_host_model.rx_word), 41'(exp), "word out");
    end
  endtask

  task automatic xfer(input logic [15:0] w, input logic [15:0] exp);
    int n;
    n = i_scw_host_model.rx_count;
    i_scw_host_model.send(w);
    chk_word(n, exp);
  endtask

  task automatic adc(input logic [15:0] w, input logic [15:0] exp);
    int n;
    n = i_scw_host_model.rx_count;
    @(posedge i_clk);
    i_adc_word <= w;
    i_adc_valid <= 1'b1;
    @(posedge i_clk);
    i_adc_valid <= 1'b0;
    chk_word(n, exp);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_scw_host_model.send(cw(1'b0, 3'h0, a, d));
    if (a < 3'h6) sh[a] = d;
  endtask

  // Transmitter needs 17 rising edges to finish a word
  task automatic drain();
    repeat (20) @(posedge o_sclk);
  endtask

  // ====================
  // Scenarios
  // ====================
  task automatic t_regs();
    logic [7:0] tbl [6] = '{8'h70, 8'h17, 8'h60, 8'h8B, 8'h5D, 8'h3E};
    for (int i = 0; i < 6; i++) begin
      wr(3'(i), tbl[i]);
      chk(cfg, exp_cfg(), "reg write");
    end
    wr(3'h7, 8'hFF);
    chk(cfg, exp_cfg(), "reserved addr");
    wr(3'h2, 8'h61);
    chk(cfg, exp_cfg(), "global power");
  endtask

  task automatic t_refused();
    int n;
    n = inv_seen;
    i_scw_host_model.send(16'h0155);
    chk(41'(inv_seen - n), 41'h1, "invalid flag");
    xfer(cw(1'b0, 3'h1, 3'h2, 8'h2A), 16'h822A);
    chk(cfg, exp_cfg(), "forward only");
    xfer(cw(1'b1, 3'h0, 3'h3, 8'h00), 16'hC38B);
    xfer(cw(1'b1, 3'h0, 3'h6, 8'h00), 16'hC600);
  endtask

  task automatic t_diag();
    wr(3'h1, 8'h87);
    chk(cfg, exp_cfg(), "echo bit");
    drain();
    xfer(cw(1'b0, 3'h0, 3'h4, 8'h5D), 16'h845D);
    wr(3'h1, 8'h07);
    drain();
    wr(3'h0, 8'h78);
    chk(cfg, exp_cfg(), "loop bit");
    drain();
    xfer(cw(1'b0, 3'h0, 3'h5, 8'h3E), 16'h853E);
    wr(3'h0, 8'h70);
    drain();
  endtask

  task automatic t_modes();
    int n;
    wr(3'h0, 8'h72);
    chk(cfg, exp_cfg(), "mixed bit");
    adc(16'h1235, 16'h091A);
    n = inv_seen;
    i_scw_host_model.send(16'h0355);
    chk(41'(inv_seen - n), 41'h0, "mixed data word");
    wr(3'h0, 8'h80);
    for (int i = 0; i < 6; i++) sh[i] = 8'h00;
    chk(cfg, exp_cfg(), "soft reset");
    wr(3'h0, 8'h01);
    chk(cfg, exp_cfg(), "data mode");
    i_scw_host_model.send(cw(1'b0, 3'h0, 3'h2, 8'h61));
    chk(cfg, exp_cfg(), "data mode input");
    adc(16'hABCD, 16'hABCD);
  endtask

  // ====================
  // Run
  // ====================
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    num_errors++;
    $display("unexpected at %0t: run too long", $time);
    end_sim();
  end

  initial begin
    for (int i = 0; i < 6; i++) sh[i] = 8'h00;
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    chk(cfg, exp_cfg(), "reset values");
    t_regs();
    t_refused();
    t_diag();
    t_modes();
    end_sim();
  end
endmodule
